// file: src/upstream_charger_detect.sv
// Upstream charger detection state machine and charger detect outputs
`timescale 1ns/1ps
module upstream_charger_detect
    import chg_det_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Stage and configuration levels
    input wire logic detect_enable_i,
    input wire logic enhanced_detect_enable_i,
    input wire logic charger_detect_stage_i,
    input wire logic wait_reference_clock_stage_i,
    input wire logic osc_detect_enable_i,
    input wire logic upstream_hsic_i,
    input wire logic [7:0] type_mask_i,
    input wire logic [1:0] pin_enable_i,
    input wire logic event_mode_i,
    // Device events and bus power
    input wire logic vbus_present_i,
    input wire logic configured_i,
    input wire logic suspend_i,
    // Software override of the probe drive and charger type, and interrupt clear
    input wire logic sw_override_i,
    input wire logic sw_probe_en_i,
    input wire logic [2:0] sw_type_i,
    input wire logic sw_type_load_i,
    input wire logic irq_clear_i,
    // Analog line classification from the upstream comparators
    input wire logic [2:0] line_code_i,
    output logic probe_en_o,
    output logic [2:0] charger_type_o,
    output logic [1:0] charger_detect_status_field_o,
    output logic [1:0] charger_detect_pins_o,
    output logic detect_done_o,
    output logic irq_o
);

    // ****************************************************
    // Reset release and input synchronisation
    // ****************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Line comparators and bus power are analog and asynchronous to the core clock
    // Bundle layout: line code in the low bits, bus power on top
    localparam int LINE_W = $bits(LINE_OPEN);
    localparam int SYNC_W = LINE_W + 1;
    localparam int VBUS_BIT = LINE_W;
    logic [SYNC_W-1:0] async_bundle;
    logic [SYNC_W-1:0] sync_bundle;
    logic [LINE_W-1:0] line_s;
    logic vbus_s;

    assign async_bundle = {vbus_present_i, line_code_i};

    sync2 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .async_i(async_bundle),
        .sync_o(sync_bundle)
    );

    assign line_s = sync_bundle[LINE_W-1:0];
    assign vbus_s = sync_bundle[VBUS_BIT];

    // ****************************************************
    // Detection state machine
    // ****************************************************
    det_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0] type_q, type_d;
    logic done_q, done_d;
    logic irq_q, irq_d;
    logic stage_q, stage_d;
    logic start;
    logic allowed;
    logic [2:0] classified;
    logic [2:0] line_prev_q;
    logic line_stable;

    // Oscillator mode lets the wait-for-clock stage start a run as well
    assign stage_d = charger_detect_stage_i
        | (wait_reference_clock_stage_i & osc_detect_enable_i);
    // Only a fresh stage entry starts a run; an HSIC upstream link never starts a hardware run
    assign allowed = detect_enable_i & ~upstream_hsic_i;
    assign start = stage_d & ~stage_q & allowed;
    // Code bits cross one by one, so a class waits for two samples to agree, for at most one settle period
    assign line_stable = (line_s == line_prev_q);

    always_comb
    begin
        unique case (line_s)
            LINE_SHORTED: classified = TYPE_DCP;
            LINE_PULLDOWN: classified = TYPE_SDP;
            LINE_REFLECT: classified = enhanced_detect_enable_i ? TYPE_CDP : TYPE_NONE;
            LINE_DP20_DM20: classified = TYPE_LOW_CUR;
            LINE_DP20_DM27: classified = TYPE_HIGH_CUR;
            LINE_DP27_DM20: classified = TYPE_SUPER_CUR;
            default: classified = TYPE_NONE;
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        type_d = type_q;
        done_d = done_q;
        irq_d = irq_q & ~irq_clear_i;
        unique case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    state_d = ST_PROBE;
                    done_d = 1'b0;
                end
            end
            ST_PROBE:
            begin
                cnt_d = CNT_W'(SETTLE_CYCLES - 1);
                state_d = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                if (cnt_q == '0)
                begin
                    state_d = ST_CLASSIFY;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_CLASSIFY:
            begin
                // A code still moving after another settle period is taken as it stands
                if (line_stable || cnt_q == CNT_W'(SETTLE_CYCLES - 1))
                begin
                    type_d = classified;
                    done_d = 1'b1;
                    cnt_d = '0;
                    state_d = ST_DONE;
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_DONE:
            begin
                // Raise set wins over a simultaneous software clear
                irq_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // No interlock: software may load a type at any stage
        if (sw_override_i && sw_type_load_i)
        begin
            type_d = sw_type_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            type_q <= TYPE_NONE;
            done_q <= 1'b0;
            irq_q <= 1'b0;
            stage_q <= 1'b0;
            line_prev_q <= LINE_OPEN;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            type_q <= type_d;
            done_q <= done_d;
            irq_q <= irq_d;
            stage_q <= stage_d;
            line_prev_q <= line_s;
        end
    end

    // ****************************************************
    // Detect status field and pins
    // ****************************************************
    logic [1:0] field_q, field_d;
    logic [1:0] pins_q, pins_d;
    logic probe_q, probe_d;
    logic charger_hit;

    // Mask bit per type code decides whether a charger moves the pins
    assign charger_hit = (type_q != TYPE_NONE) & type_mask_i[type_q];

    always_comb
    begin
        if (charger_hit && !event_mode_i)
        begin
            field_d = DET_CHARGER;
        end
        else if (configured_i && !suspend_i)
        begin
            field_d = DET_CONFIGURED;
        end
        else if (vbus_s && !suspend_i)
        begin
            field_d = DET_VBUS;
        end
        else
        begin
            field_d = DET_NONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            field_q <= DET_NONE;
        end
        else
        begin
            field_q <= field_d;
        end
    end

    // Pins track the field a cycle later; a disabled pin is held low
    // Each bit is gated alone so either one can serve on a single pin
    for (genvar b = 0; b < $bits(field_q); b++)
    begin : g_pin
        assign pins_d[b] = field_q[b] & pin_enable_i[b];
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_q <= DET_NONE;
        end
        else
        begin
            pins_q <= pins_d;
        end
    end

    // Probe drive: hardware run, or software with no interlock
    always_comb
    begin
        probe_d = (state_q == ST_PROBE) | (state_q == ST_SETTLE)
            | (sw_override_i & sw_probe_en_i);
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            probe_q <= 1'b0;
        end
        else
        begin
            probe_q <= probe_d;
        end
    end

    assign probe_en_o = probe_q;
    assign charger_type_o = type_q;
    assign charger_detect_status_field_o = field_q;
    assign charger_detect_pins_o = pins_q;
    assign detect_done_o = done_q;
    assign irq_o = irq_q;

endmodule

// file: src/chg_det_pkg.sv
// Package of constants and types for the upstream charger detection block
package chg_det_pkg;

    // Charger type codes reported by the detection sequence
    localparam logic [2:0] TYPE_NONE = 3'h0;
    localparam logic [2:0] TYPE_DCP = 3'h1;
    localparam logic [2:0] TYPE_CDP = 3'h2;
    localparam logic [2:0] TYPE_SDP = 3'h3;
    localparam logic [2:0] TYPE_LOW_CUR = 3'h4;
    localparam logic [2:0] TYPE_HIGH_CUR = 3'h5;
    localparam logic [2:0] TYPE_SUPER_CUR = 3'h6;

    // Two-bit detect output encodings
    localparam logic [1:0] DET_NONE = 2'h0;
    localparam logic [1:0] DET_VBUS = 2'h1;
    localparam logic [1:0] DET_CONFIGURED = 2'h2;
    localparam logic [1:0] DET_CHARGER = 2'h3;

    // Line probe codes presented by the analog comparators
    localparam logic [2:0] LINE_OPEN = 3'h0;
    localparam logic [2:0] LINE_SHORTED = 3'h1;
    localparam logic [2:0] LINE_REFLECT = 3'h2;
    localparam logic [2:0] LINE_PULLDOWN = 3'h3;
    localparam logic [2:0] LINE_DP20_DM20 = 3'h4;
    localparam logic [2:0] LINE_DP20_DM27 = 3'h5;
    localparam logic [2:0] LINE_DP27_DM20 = 3'h6;

    // Settling time of each probe step
    localparam int SETTLE_US = 40;
    localparam int CLK_MHZ = 25;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PROBE = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_CLASSIFY = 5'b01000,
        ST_DONE = 5'b10000
    } det_state_t;

endpackage

// file: src/sync2.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// file: dv/upstream_charger_detect_assertions.sv
// Port checker for the upstream charger detection block
`timescale 1ns/1ps
module upstream_charger_detect_assertions
    import chg_det_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic upstream_hsic_i,
    input wire logic [7:0] type_mask_i,
    input wire logic [1:0] pin_enable_i,
    input wire logic event_mode_i,
    input wire logic suspend_i,
    input wire logic sw_override_i,
    input wire logic irq_clear_i,
    input wire logic probe_en_o,
    input wire logic [2:0] charger_type_o,
    input wire logic [1:0] charger_detect_status_field_o,
    input wire logic [1:0] charger_detect_pins_o,
    input wire logic detect_done_o,
    input wire logic irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    int probe_q;
    int hsic_q;
    // ****************
    // Helper counters
    // ****************
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            probe_q <= 0;
            hsic_q <= 0;
        end
        else
        begin
            probe_q <= probe_en_o ? probe_q + 1 : 0;
            hsic_q <= upstream_hsic_i ? hsic_q + 1 : 0;
        end
    end
    property p_pins;
        $stable(pin_enable_i) |->
            charger_detect_pins_o == ($past(charger_detect_status_field_o) & pin_enable_i);
    endproperty
    a_pins: assert property (p_pins) else $error("pins off field");
    property p_irq;
        $rose(detect_done_o) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("no irq after done");
    property p_clear;
        irq_clear_i && !$rose(detect_done_o) |=> !irq_o;
    endproperty
    a_clear: assert property (p_clear) else $error("irq not cleared");
    property p_width;
        $fell(probe_en_o) && !sw_override_i |-> probe_q inside {[SETTLE_CYCLES:SETTLE_CYCLES+1]};
    endproperty
    a_width: assert property (p_width) else $error("probe width wrong");
    property p_hsic;
        hsic_q > SETTLE_CYCLES + 8 && !sw_override_i |-> !$rose(detect_done_o);
    endproperty
    a_hsic: assert property (p_hsic) else $error("run on link");
    property p_reset;
        $rose(rstn_i) |-> charger_type_o == TYPE_NONE && !irq_o
            && charger_detect_status_field_o == DET_NONE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_susp;
        (event_mode_i && suspend_i)[*3] |-> charger_detect_status_field_o == DET_NONE;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend not none");
    property p_chg;
        $rose(detect_done_o) && !event_mode_i && !suspend_i && charger_type_o != TYPE_NONE
            && type_mask_i[charger_type_o] |=> charger_detect_status_field_o == DET_CHARGER;
    endproperty
    a_chg: assert property (p_chg) else $error("charger not shown");
    c_irq: cover property ($rose(irq_o));
    c_susp: cover property (event_mode_i && suspend_i);
    c_hsic: cover property (hsic_q > SETTLE_CYCLES + 8);
endmodule

bind upstream_charger_detect upstream_charger_detect_assertions
    #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

// file: dv/line_model.sv
// Upstream port line model seen through the comparators
`timescale 1ns/1ps
module line_model
    import chg_det_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic probe_en_i,
    input wire logic [2:0] attach_i,
    output logic [2:0] line_code_o
);
    logic [2:0] hold_q = 3'h0;
    // Profile fades a few cycles after the probe drive stops, then lines read open
    always_ff @(posedge core_clk_i)
        hold_q <= probe_en_i ? 3'h4 : (hold_q != 3'h0) ? hold_q - 3'h1 : hold_q;
    assign line_code_o = (probe_en_i || hold_q != 3'h0) ? attach_i : LINE_OPEN;
endmodule

// file: dv/upstream_charger_detect_tb.sv
// Self-checking bench for upstream charger detection
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module upstream_charger_detect_tb;
    import chg_det_pkg::*;
    logic core_clk_i = 0, rstn_i = 0, detect_enable_i = 1, enhanced_detect_enable_i = 1;
    logic charger_detect_stage_i = 0, wait_reference_clock_stage_i = 0, osc_detect_enable_i = 1;
    logic upstream_hsic_i = 0, event_mode_i = 0, vbus_present_i = 0, configured_i = 0;
    logic suspend_i = 0, sw_override_i = 0, sw_probe_en_i = 0, sw_type_load_i = 0;
    logic irq_clear_i = 0, probe_en_o, detect_done_o, irq_o, got;
    logic [7:0] type_mask_i = 8'hfe;
    logic [1:0] pin_enable_i = 2'h3, charger_detect_status_field_o, charger_detect_pins_o;
    logic [2:0] sw_type_i = 3'h0, line_code_i, charger_type_o, attach = 3'h0;
    logic [2:0] lc [6] = '{LINE_SHORTED, LINE_REFLECT, LINE_PULLDOWN, LINE_DP20_DM20,
        LINE_DP20_DM27, LINE_DP27_DM20};
    logic [2:0] ty [6] = '{TYPE_DCP, TYPE_CDP, TYPE_SDP, TYPE_LOW_CUR, TYPE_HIGH_CUR,
        TYPE_SUPER_CUR};
    int num_errors = 0, num_checks = 0;

    upstream_charger_detect #(.SETTLE_CYCLES(4)) u_dut (.*);
    line_model u_line (.core_clk_i(core_clk_i), .probe_en_i(probe_en_o), .attach_i(attach),
        .line_code_o(line_code_i));

    initial forever #20 core_clk_i = ~core_clk_i;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Flag is cleared first so a blocked start shows as a missing flag
    task automatic run(input logic w);
        int k;
        irq_clear_i <= 1'b1;
        tick(1);
        irq_clear_i <= 1'b0;
        if (w)
            wait_reference_clock_stage_i <= 1'b1;
        else
            charger_detect_stage_i <= 1'b1;
        k = 0;
        do
            @(negedge core_clk_i);
        while (irq_o !== 1'b1 && k++ < 30);
        got = irq_o;
        tick(1);
        charger_detect_stage_i <= 1'b0;
        wait_reference_clock_stage_i <= 1'b0;
        @(negedge core_clk_i);
    endtask

    // ****************
    // Test sequence
    // ****************
    initial
    begin
        tick(2);
        rstn_i <= 1'b1;
        @(negedge core_clk_i);
        `CHK({charger_type_o, charger_detect_pins_o, irq_o}, 6'h0)
        tick(3);
        for (int i = 0; i < 6; i++)
        begin
            tick(1);
            attach <= lc[i];
            pin_enable_i <= (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h3;
            run(i == 5);
            `CHK(got, 1'b1)
            `CHK(detect_done_o, 1'b1)
            `CHK(charger_type_o, ty[i])
            `CHK(charger_detect_status_field_o, DET_CHARGER)
            `CHK(charger_detect_pins_o, DET_CHARGER & pin_enable_i)
        end
        tick(1);
        type_mask_i <= 8'hf6;
        vbus_present_i <= 1'b1;
        attach <= LINE_PULLDOWN;
        run(1'b0);
        `CHK(charger_detect_status_field_o, DET_VBUS)
        tick(1);
        enhanced_detect_enable_i <= 1'b0;
        attach <= LINE_REFLECT;
        run(1'b0);
        `CHK(charger_type_o == TYPE_CDP, 1'b0)
        tick(1);
        event_mode_i <= 1'b1;
        configured_i <= 1'b1;
        tick(4);
        @(negedge core_clk_i);
        `CHK(charger_detect_pins_o, DET_CONFIGURED)
        tick(1);
        suspend_i <= 1'b1;
        tick(4);
        @(negedge core_clk_i);
        `CHK(charger_detect_pins_o, DET_NONE)
        tick(1);
        event_mode_i <= 1'b0;
        suspend_i <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            tick(1);
            upstream_hsic_i <= (i == 0);
            detect_enable_i <= (i != 1);
            osc_detect_enable_i <= (i != 2);
            run(i == 2);
            `CHK({got, probe_en_o}, 2'h0)
        end
        tick(1);
        detect_enable_i <= 1'b1;
        sw_override_i <= 1'b1;
        sw_probe_en_i <= 1'b1;
        sw_type_i <= TYPE_HIGH_CUR;
        sw_type_load_i <= 1'b1;
        tick(1);
        sw_type_load_i <= 1'b0;
        tick(2);
        @(negedge core_clk_i);
        `CHK({probe_en_o, charger_type_o}, {1'b1, TYPE_HIGH_CUR})
        tick(1);
        sw_probe_en_i <= 1'b0;
        tick(2);
        sw_override_i <= 1'b0;
        charger_detect_stage_i <= 1'b1;
        tick(3);
        rstn_i <= 1'b0;
        tick(2);
        @(negedge core_clk_i);
        `CHK({charger_type_o, charger_detect_pins_o, irq_o, probe_en_o}, 7'h0)
        test_done();
    end

    initial
    begin
        tick(3000);
        num_errors++;
        test_done();
    end
endmodule
